//--- drive_state_velocity_objects.sv
// Drive power state machine, command and state words, velocity objects.
`timescale 1ns/10ps
module drive_state_velocity_objects
  import drive_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // Object access port
  input wire logic obj_wr_i,
  input wire logic obj_rd_i,
  input wire logic [15:0] obj_index_i,
  input wire logic [7:0] obj_sub_i,
  input wire logic [31:0] obj_wdata_i,
  output logic [31:0] obj_rdata_o,
  output logic obj_ack_o,
  output logic obj_err_o,
  // Process-data update strobe
  input wire logic pd_update_i,
  // Drive status pins
  input wire logic fault_i,
  input wire logic fault_react_done_i,
  input wire logic warning_i,
  input wire logic sync_i,
  input wire logic setup_ok_i,
  input wire logic index_seen_i,
  input wire logic open_loop_i,
  input wire logic speed_src_encoder_i,
  input wire logic [15:0] speed_calc_i,
  input wire logic [15:0] speed_encoder_i,
  input wire logic [7:0] op_mode_i,
  input wire logic [1:0] mode_status_i,
  // Drive control outputs
  output logic [15:0] state_word_o,
  output logic [15:0] speed_demand_o,
  output logic power_applied_o,
  output logic run_enable_o,
  output logic quick_halt_active_o,
  output logic halt_o,
  output logic [3:0] mode_specific_bits_o
);
  // Asynchronous pins pass two flip-flops before use.
  logic [5:0] pin_meta_r;
  logic [5:0] pin_sync_r;
  logic fault_s, react_done_s, warn_s, sync_s, setup_s, index_s;
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pin_meta_r <= 6'h00;
      pin_sync_r <= 6'h00;
    end
    else
    begin
      pin_meta_r <= {fault_i, fault_react_done_i, warning_i, sync_i, setup_ok_i, index_seen_i};
      pin_sync_r <= pin_meta_r;
    end
  end
  assign {fault_s, react_done_s, warn_s, sync_s, setup_s, index_s} = pin_sync_r;

  logic [15:0] command_r;
  logic signed [15:0] target_r;
  logic [31:0] min_r;
  logic [31:0] max_r;
  logic [15:0] cmd_latched_r;
  power_state_e state_r, state_nxt;
  logic signed [15:0] demand_nxt;
  logic limit_nxt;
  logic index_ok;
  logic sub_ok;
  assign index_ok = obj_index_i inside {IDX_COMMAND, IDX_STATE, IDX_TARGET, IDX_DEMAND,
                                        IDX_ACTUAL, IDX_LIMITS};
  assign sub_ok = (obj_index_i == IDX_LIMITS) ? (obj_sub_i <= LIMITS_SUB_COUNT)
                                              : (obj_sub_i == SUB_COUNT);

  // Writable objects; read-only objects refuse writes with an error.
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      command_r <= COMMAND_RST;
      target_r <= TARGET_RST;
      min_r <= MIN_RST;
      max_r <= MAX_RST;
    end
    else if (obj_wr_i && sub_ok)
    begin
      if (obj_index_i == IDX_COMMAND)
        command_r <= obj_wdata_i[15:0];
      else if (obj_index_i == IDX_TARGET)
        target_r <= obj_wdata_i[15:0];
      else if (obj_index_i == IDX_LIMITS && obj_sub_i == SUB_MIN)
        min_r <= obj_wdata_i;
      else if (obj_index_i == IDX_LIMITS && obj_sub_i == SUB_MAX)
        max_r <= obj_wdata_i;
    end
  end

  // The command word is sampled once per process-data update.
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      cmd_latched_r <= COMMAND_RST;
    else if (pd_update_i)
      cmd_latched_r <= command_r;
  end

  // On an update the freshly written word acts at once; otherwise the latched copy holds.
  logic [15:0] cmd_now;
  assign cmd_now = pd_update_i ? command_r : cmd_latched_r;

  logic c_on, c_volt, c_quick_n, c_run, c_clr;
  assign c_on = cmd_now[CMD_SWITCH_ON];
  assign c_volt = cmd_now[CMD_VOLTAGE];
  assign c_quick_n = cmd_now[CMD_QUICK_N];
  assign c_run = cmd_now[CMD_RUN];
  assign c_clr = cmd_now[CMD_FAULT_CLR];

  // Fault wins over every command; reset and fault reaction move on without an update.
  always_comb
  begin
    state_nxt = state_r;
    if (fault_s && !(state_r inside {PS_FAULT_REACT, PS_FAULT}))
      state_nxt = PS_FAULT_REACT;
    else if (pd_update_i || state_r inside {PS_NOT_READY, PS_FAULT_REACT})
    begin
      unique case (state_r)
        PS_NOT_READY: state_nxt = PS_INHIBITED;
        PS_INHIBITED:
          if (c_volt && c_quick_n && !c_on)
            state_nxt = PS_READY;
        PS_READY:
          if (!c_volt || !c_quick_n)
            state_nxt = PS_INHIBITED;
          else if (c_on)
            state_nxt = PS_SWITCHED;
        PS_SWITCHED:
          if (!c_volt)
            state_nxt = PS_INHIBITED;
          else if (!c_quick_n)
            state_nxt = PS_INHIBITED;
          else if (!c_on)
            state_nxt = PS_READY;
          else if (c_run)
            state_nxt = PS_RUNNING;
        PS_RUNNING:
          if (!c_volt)
            state_nxt = PS_INHIBITED;
          else if (!c_quick_n)
            state_nxt = PS_QUICK;
          else if (!c_on)
            state_nxt = PS_READY;
          else if (!c_run)
            state_nxt = PS_SWITCHED;
        PS_QUICK:
          if (!c_volt)
            state_nxt = PS_INHIBITED;
          else if (c_quick_n && c_run)
            state_nxt = PS_RUNNING;
        PS_FAULT_REACT:
          if (react_done_s)
            state_nxt = PS_FAULT;
        PS_FAULT:
          if (c_clr && !fault_s)
            state_nxt = PS_INHIBITED;
        default: state_nxt = PS_NOT_READY;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      state_r <= PS_NOT_READY;
    else
      state_r <= state_nxt;
  end

  function automatic logic [6:0] state_code(input power_state_e s);
    unique case (s)
      PS_NOT_READY: state_code = SW_NOT_READY;
      PS_INHIBITED: state_code = SW_INHIBITED;
      PS_READY: state_code = SW_READY;
      PS_SWITCHED: state_code = SW_SWITCHED;
      PS_RUNNING: state_code = SW_RUNNING;
      PS_QUICK: state_code = SW_QUICK;
      PS_FAULT_REACT: state_code = SW_FAULT_REACT;
      PS_FAULT: state_code = SW_FAULT;
      default: state_code = SW_NOT_READY;
    endcase
  endfunction

  // Voltage stays applied from ready to switch on through quick stop.
  function automatic logic voltage_applied(input power_state_e s);
    voltage_applied = s inside {PS_READY, PS_SWITCHED, PS_RUNNING, PS_QUICK};
  endfunction

  // Halt is honoured only in the modes that support it.
  logic halt_mode;
  assign halt_mode = op_mode_i inside {MODE_PROFILE_POS, MODE_VELOCITY, MODE_PROFILE_VEL,
                                       MODE_PROFILE_TRQ, MODE_INTERP_POS};
  logic halt_req;
  assign halt_req = halt_mode && cmd_now[CMD_HALT];

  // The clamp is combinational so the limit bit follows the target within one cycle.
  speed_clamp u_clamp
  (
    .target_i(target_r),
    .min_i(min_r),
    .max_i(max_r),
    .demand_o(demand_nxt),
    .limit_hit_o(limit_nxt)
  );

  // Demand stays at zero unless operation is enabled and no honoured halt is pending.
  logic signed [15:0] demand_r;
  logic signed [15:0] actual_r;
  logic running;
  logic [15:0] actual_nxt;
  assign running = (state_nxt == PS_RUNNING);
  assign actual_nxt = (open_loop_i && !speed_src_encoder_i) ? speed_calc_i
                                                           : speed_encoder_i;

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      demand_r <= DEMAND_RST;
      actual_r <= ACTUAL_RST;
    end
    else
    begin
      demand_r <= (running && !halt_req) ? demand_nxt : DEMAND_RST;
      actual_r <= actual_nxt;
    end
  end

  // State word is built from the next state so it changes with the state.
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      state_word_o <= 16'h0000;
    else
    begin
      state_word_o <= 16'h0000;
      state_word_o[6:0] <= state_code(state_nxt);
      state_word_o[4] <= voltage_applied(state_nxt) ? VOLTAGE_BIT : 1'b0;
      state_word_o[ST_WARN] <= warn_s;
      state_word_o[ST_SYNC] <= sync_s;
      state_word_o[ST_REMOTE] <= 1'b1;
      state_word_o[ST_GOAL] <= running && (actual_r == demand_r);
      state_word_o[ST_LIMIT] <= limit_nxt;
      state_word_o[13:12] <= mode_status_i;
      state_word_o[ST_CLOSED] <= setup_s && index_s;
    end
  end

  // Drive control outputs.
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      power_applied_o <= 1'b0;
      run_enable_o <= 1'b0;
      quick_halt_active_o <= 1'b0;
      halt_o <= 1'b0;
      mode_specific_bits_o <= 4'h0;
      speed_demand_o <= 16'h0000;
    end
    else
    begin
      power_applied_o <= voltage_applied(state_nxt);
      run_enable_o <= running;
      quick_halt_active_o <= (state_nxt == PS_QUICK);
      halt_o <= halt_req;
      mode_specific_bits_o <= {cmd_now[9], cmd_now[6:4]};
      speed_demand_o <= demand_r;
    end
  end

  // A write to a read-only object or to the limits subindex count is refused.
  logic obj_access;
  logic obj_refused;
  assign obj_access = obj_wr_i || obj_rd_i;
  assign obj_refused = !index_ok || !sub_ok ||
                       (obj_wr_i && obj_index_i inside {IDX_STATE, IDX_DEMAND, IDX_ACTUAL}) ||
                       (obj_wr_i && obj_sub_i == SUB_COUNT && obj_index_i == IDX_LIMITS);

  // Object read answers stand for one cycle with the acknowledge.
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      obj_rdata_o <= 32'h0000_0000;
      obj_ack_o <= 1'b0;
      obj_err_o <= 1'b0;
    end
    else
    begin
      obj_ack_o <= obj_access;
      obj_err_o <= obj_access && obj_refused;
      obj_rdata_o <= 32'h0000_0000;
      if (obj_rd_i && sub_ok)
      begin
        unique case (obj_index_i)
          IDX_COMMAND: obj_rdata_o <= {16'h0000, command_r};
          IDX_STATE: obj_rdata_o <= {16'h0000, state_word_o};
          IDX_TARGET: obj_rdata_o <= {16'h0000, target_r};
          IDX_DEMAND: obj_rdata_o <= {16'h0000, demand_r};
          IDX_ACTUAL: obj_rdata_o <= {16'h0000, actual_r};
          IDX_LIMITS:
            obj_rdata_o <= (obj_sub_i == SUB_MIN) ? min_r :
                           (obj_sub_i == SUB_MAX) ? max_r : {24'h00_0000, LIMITS_SUB_COUNT};
          default: obj_rdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

//--- drive_pkg.sv
// Package with object indices, field positions, reset values and state codes.
package drive_pkg;
  localparam logic [15:0] IDX_COMMAND = 16'h6040;
  localparam logic [15:0] IDX_STATE = 16'h6041;
  localparam logic [15:0] IDX_TARGET = 16'h6042;
  localparam logic [15:0] IDX_DEMAND = 16'h6043;
  localparam logic [15:0] IDX_ACTUAL = 16'h6044;
  localparam logic [15:0] IDX_LIMITS = 16'h6046;
  localparam logic [7:0] SUB_MIN = 8'h01;
  localparam logic [7:0] SUB_MAX = 8'h02;
  localparam logic [7:0] SUB_COUNT = 8'h00;
  localparam logic [7:0] LIMITS_SUB_COUNT = 8'h02;
  localparam logic [15:0] COMMAND_RST = 16'h0000;
  localparam logic [15:0] TARGET_RST = 16'h00c8;
  localparam logic [15:0] DEMAND_RST = 16'h0000;
  localparam logic [15:0] ACTUAL_RST = 16'h0000;
  localparam logic [31:0] MIN_RST = 32'h0000_0000;
  localparam logic [31:0] MAX_RST = 32'h0000_4e20;
  // Command word bit positions.
  localparam int CMD_SWITCH_ON = 0;
  localparam int CMD_VOLTAGE = 1;
  localparam int CMD_QUICK_N = 2;
  localparam int CMD_RUN = 3;
  localparam int CMD_FAULT_CLR = 7;
  localparam int CMD_HALT = 8;
  // State word bit positions.
  localparam int ST_WARN = 7;
  localparam int ST_SYNC = 8;
  localparam int ST_REMOTE = 9;
  localparam int ST_GOAL = 10;
  localparam int ST_LIMIT = 11;
  localparam int ST_CLOSED = 15;
  // Operating mode codes that honour halt.
  localparam logic [7:0] MODE_PROFILE_POS = 8'h01;
  localparam logic [7:0] MODE_VELOCITY = 8'h02;
  localparam logic [7:0] MODE_PROFILE_VEL = 8'h03;
  localparam logic [7:0] MODE_PROFILE_TRQ = 8'h04;
  localparam logic [7:0] MODE_INTERP_POS = 8'h07;
  // Power states, one-hot.
  typedef enum logic [7:0] {
    PS_NOT_READY = 8'b0000_0001,
    PS_INHIBITED = 8'b0000_0010,
    PS_READY = 8'b0000_0100,
    PS_SWITCHED = 8'b0000_1000,
    PS_RUNNING = 8'b0001_0000,
    PS_QUICK = 8'b0010_0000,
    PS_FAULT_REACT = 8'b0100_0000,
    PS_FAULT = 8'b1000_0000
  } power_state_e;
  // Low seven state-word bits for each power state.
  localparam logic [6:0] SW_NOT_READY = 7'b000_0000;
  localparam logic [6:0] SW_INHIBITED = 7'b100_0000;
  localparam logic [6:0] SW_READY = 7'b010_0001;
  localparam logic [6:0] SW_SWITCHED = 7'b010_0011;
  localparam logic [6:0] SW_RUNNING = 7'b010_0111;
  localparam logic [6:0] SW_QUICK = 7'b000_0111;
  localparam logic [6:0] SW_FAULT_REACT = 7'b000_1111;
  localparam logic [6:0] SW_FAULT = 7'b000_1000;
  localparam logic VOLTAGE_BIT = 1'b1;
endpackage

//--- speed_clamp.sv
// Limits a signed target speed to the configured minimum and maximum.
`timescale 1ns/10ps
module speed_clamp
(
  // Inputs
  input wire logic signed [15:0] target_i,
  input wire logic [31:0] min_i,
  input wire logic [31:0] max_i,
  // Outputs
  output logic signed [15:0] demand_o,
  output logic limit_hit_o
);
  logic signed [32:0] t_ext;
  logic signed [32:0] lo_ext;
  logic signed [32:0] hi_ext;
  assign t_ext = 33'(target_i);
  assign lo_ext = $signed({1'b0, min_i});
  assign hi_ext = $signed({1'b0, max_i});
  always_comb
  begin
    demand_o = target_i;
    limit_hit_o = 1'b0;
    // The clamp acts on magnitude so that reverse speeds are limited too.
    if (t_ext < 0)
    begin
      if (-t_ext < lo_ext)
      begin
        demand_o = -16'(min_i);
        limit_hit_o = 1'b1;
      end
      else if (-t_ext > hi_ext)
      begin
        demand_o = -16'(max_i);
        limit_hit_o = 1'b1;
      end
    end
    else if (t_ext < lo_ext)
    begin
      demand_o = 16'(min_i);
      limit_hit_o = 1'b1;
    end
    else if (t_ext > hi_ext)
    begin
      demand_o = 16'(max_i);
      limit_hit_o = 1'b1;
    end
  end
endmodule

//--- drive_checker_assertions.sv
// Checker for object port timing and state word relations.
`timescale 1ns/10ps
module drive_checker
  import drive_pkg::*;
(
  // Clock, reset and object port
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic obj_wr_i,
  input wire logic obj_rd_i,
  input wire logic obj_ack_o,
  input wire logic obj_err_o,
  // Status pins and drive outputs
  input wire logic warning_i,
  input wire logic sync_i,
  input wire logic setup_ok_i,
  input wire logic index_seen_i,
  input wire logic [15:0] state_word_o,
  input wire logic [15:0] speed_demand_o,
  input wire logic run_enable_o,
  input wire logic quick_halt_active_o,
  input wire logic halt_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  logic [6:0] code;
  assign code = state_word_o[6:0] & 7'h6f;
  property p_ack;
    (obj_wr_i || obj_rd_i) |=> obj_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack missing after access");
  property p_err;
    obj_err_o |-> obj_ack_o;
  endproperty
  a_err: assert property (p_err) else $error("error without ack");
  property p_remote;
    $past(rstn_i) |-> state_word_o[ST_REMOTE];
  endproperty
  a_remote: assert property (p_remote) else $error("remote bit low");
  property p_code;
    $past(rstn_i) |-> code inside {7'h00, 7'h40, 7'h21, 7'h23, 7'h27, 7'h07, 7'h0f, 7'h08};
  endproperty
  a_code: assert property (p_code) else $error("illegal state code");
  property p_warn;
    ($stable(warning_i))[*6] |-> state_word_o[ST_WARN] == warning_i;
  endproperty
  a_warn: assert property (p_warn) else $error("warning bit wrong");
  property p_sync;
    ($stable(sync_i))[*6] |-> state_word_o[ST_SYNC] == sync_i;
  endproperty
  a_sync: assert property (p_sync) else $error("sync bit wrong");
  property p_closed;
    (setup_ok_i && index_seen_i)[*6] |-> state_word_o[ST_CLOSED];
  endproperty
  a_closed: assert property (p_closed) else $error("closed loop bit low");
  property p_quick;
    quick_halt_active_o |-> code == SW_QUICK;
  endproperty
  a_quick: assert property (p_quick) else $error("quick stop code wrong");
  property p_demand;
    speed_demand_o != 16'h0000 |-> $past(run_enable_o) && !$past(halt_o);
  endproperty
  a_demand: assert property (p_demand) else $error("demand while not running");
endmodule
bind drive_state_velocity_objects drive_checker u_chk (.mclk_i, .rstn_i, .obj_wr_i,
  .obj_rd_i, .obj_ack_o, .obj_err_o, .warning_i, .sync_i, .setup_ok_i, .index_seen_i,
  .state_word_o, .speed_demand_o, .run_enable_o, .quick_halt_active_o, .halt_o);

//--- fieldbus_ctl.sv
// Fieldbus controller model issuing object accesses and update strobes.
`timescale 1ns/10ps
module fieldbus_ctl
  import drive_pkg::*;
(
  // Clock
  input wire logic mclk_i,
  // Object access and update strobes
  output logic obj_wr_o,
  output logic obj_rd_o,
  output logic [15:0] obj_index_o,
  output logic [7:0] obj_sub_o,
  output logic [31:0] obj_wdata_o,
  output logic pd_update_o
);
  initial
  begin
    {obj_wr_o, obj_rd_o, pd_update_o} = 3'h0;
    {obj_index_o, obj_sub_o, obj_wdata_o} = 56'h0;
  end
  function automatic logic [15:0] power_cmd(input logic so, input logic run);
    power_cmd = 16'h0000;
    power_cmd[CMD_QUICK_N] = 1'b1;
    power_cmd[CMD_VOLTAGE] = 1'b1;
    power_cmd[CMD_SWITCH_ON] = so;
    power_cmd[CMD_RUN] = run;
  endfunction
  // Released index, subindex and data lines show the inverse so stale values cannot pass; both strobes drop to zero.
  task automatic access(input logic w, input logic [15:0] i, input logic [7:0] s,
    input logic [31:0] d);
    @(posedge mclk_i);
    #2;
    obj_wr_o = w;
    obj_rd_o = !w;
    {obj_index_o, obj_sub_o, obj_wdata_o} = {i, s, d};
    @(posedge mclk_i);
    #2;
    {obj_wr_o, obj_rd_o} = 2'h0;
    {obj_index_o, obj_sub_o, obj_wdata_o} = ~{i, s, d};
  endtask
  task automatic pulse;
    @(posedge mclk_i);
    #2;
    pd_update_o = 1'b1;
    @(posedge mclk_i);
    #2;
    pd_update_o = 1'b0;
  endtask
endmodule

//--- drive_state_velocity_objects_test.sv
// Self-checking bench for the drive state and velocity object block.
`timescale 1ns/10ps
module drive_state_velocity_objects_test
  import drive_pkg::*;
;
  typedef struct {logic [31:0] d; logic [31:0] m; logic e;} note_s;
  note_s q[$];
  note_s n;
  logic mclk_i, rstn_i, fault_i, fault_react_done_i, warning_i, sync_i, setup_ok_i;
  logic index_seen_i, open_loop_i, speed_src_encoder_i, obj_ack_o, obj_err_o, wr, rd, pd;
  logic [15:0] speed_calc_i, speed_encoder_i, idx;
  logic [7:0] op_mode_i, sub;
  logic [1:0] mode_status_i;
  logic [31:0] obj_rdata_o, wd;
  logic [15:0] state_word_o, speed_demand_o;
  logic power_applied_o, run_enable_o, quick_halt_active_o, halt_o;
  logic [3:0] mode_specific_bits_o, mb, lv;
  logic [15:0] ct[3], ce[3];
  logic [15:0] wc[4];
  logic [3:0] wo[4] = '{4'h9, 4'h9, 4'hd, 4'hb};
  logic [15:0] we[4] = '{16'h0021, 16'h0023, 16'h0027, 16'h0007};
  logic [15:0] ri[5] = '{IDX_STATE, IDX_DEMAND, IDX_ACTUAL, IDX_LIMITS, 16'h1234};
  logic [7:0] hm[5] = '{MODE_PROFILE_POS, MODE_VELOCITY, MODE_PROFILE_VEL,
    MODE_PROFILE_TRQ, MODE_INTERP_POS};
  int num_errors, checks_done, cyc;
  fieldbus_ctl u_ctl (.mclk_i, .obj_wr_o(wr), .obj_rd_o(rd), .obj_index_o(idx),
    .obj_sub_o(sub), .obj_wdata_o(wd), .pd_update_o(pd));
  drive_state_velocity_objects uut (.mclk_i, .rstn_i, .obj_wr_i(wr), .obj_rd_i(rd),
    .obj_index_i(idx), .obj_sub_i(sub), .obj_wdata_i(wd), .obj_rdata_o, .obj_ack_o,
    .obj_err_o, .pd_update_i(pd), .fault_i, .fault_react_done_i, .warning_i, .sync_i,
    .setup_ok_i, .index_seen_i, .open_loop_i, .speed_src_encoder_i, .speed_calc_i,
    .speed_encoder_i, .op_mode_i, .mode_status_i, .state_word_o, .speed_demand_o,
    .power_applied_o, .run_enable_o, .quick_halt_active_o, .halt_o,
    .mode_specific_bits_o);
  assign lv = {power_applied_o, run_enable_o, quick_halt_active_o, state_word_o[4]};
  always #25 mclk_i = ~mclk_i;
  task automatic end_sim;
    check(32'(q.size()), 32'h0);
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge mclk_i);
    #2;
  endtask
  task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] s,
    input logic [31:0] d, input logic [31:0] e, input logic [31:0] m, input logic er);
    q.push_back('{e & m, m, er});
    u_ctl.access(w, i, s, d);
  endtask
  task automatic rdv(input logic [15:0] i, input logic [7:0] s, input logic [31:0] e);
    acc(1'b0, i, s, 32'h0, e, 32'hffff_ffff, 1'b0);
  endtask
  task automatic st(input logic [15:0] e, input logic [15:0] m);
    acc(1'b0, IDX_STATE, SUB_COUNT, 32'h0, {16'h0, e}, {16'h0, m}, 1'b0);
  endtask
  task automatic cmdset(input logic [15:0] c);
    acc(1'b1, IDX_COMMAND, SUB_COUNT, {16'h0, c}, 32'h0, 32'h0, 1'b0);
    u_ctl.pulse();
    tick(2);
  endtask
  task automatic walk(input int c);
    for (int k = 0; k < c; k++)
    begin
      cmdset(wc[k]);
      st(we[k], 16'h006f);
      check({28'h0, lv}, {28'h0, wo[k]});
    end
  endtask
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      num_errors++;
      end_sim();
    end
    if (obj_ack_o === 1'b1)
    begin
      if (q.size() == 0)
        check(32'h1, 32'h0);
      else
      begin
        n = q.pop_front();
        check(obj_rdata_o & n.m, n.d);
        check({31'h0, obj_err_o}, {31'h0, n.e});
      end
    end
  end
  initial
  begin
    {mclk_i, rstn_i, fault_i, fault_react_done_i, warning_i, sync_i} = 6'h0;
    {setup_ok_i, index_seen_i, open_loop_i, speed_src_encoder_i} = 4'h0;
    {speed_calc_i, speed_encoder_i, op_mode_i, mode_status_i} = 42'h0;
    void'($urandom(32'h2bfd));
    tick(10);
    rstn_i = 1'b1;
    rdv(IDX_TARGET, SUB_COUNT, {16'h0, TARGET_RST});
    rdv(IDX_DEMAND, SUB_COUNT, 32'h0);
    rdv(IDX_ACTUAL, SUB_COUNT, 32'h0);
    rdv(IDX_LIMITS, SUB_MIN, MIN_RST);
    rdv(IDX_LIMITS, SUB_MAX, MAX_RST);
    rdv(IDX_LIMITS, SUB_COUNT, {24'h0, LIMITS_SUB_COUNT});
    rdv(IDX_COMMAND, SUB_COUNT, {16'h0, COMMAND_RST});
    st(16'h0240, 16'h83ef);
    $display("test reset values done");
    for (int k = 0; k < 5; k++)
      acc(1'b1, ri[k], SUB_COUNT, $urandom, 32'h0, 32'h0, 1'b1);
    acc(1'b0, IDX_TARGET, 8'h05, 32'h0, 32'h0, 32'h0, 1'b1);
    rdv(IDX_DEMAND, SUB_COUNT, 32'h0);
    rdv(IDX_ACTUAL, SUB_COUNT, 32'h0);
    $display("test refused accesses done");
    wc = '{u_ctl.power_cmd(1'b0, 1'b0), u_ctl.power_cmd(1'b1, 1'b0),
      u_ctl.power_cmd(1'b1, 1'b1), 16'h000b};
    walk(4);
    cmdset(16'h0000);
    st(16'h0040, 16'h006f);
    check({28'h0, lv}, 32'h0);
    $display("test power walk done");
    {warning_i, sync_i, setup_ok_i} = 3'h7;
    mode_status_i = 2'($urandom);
    tick(8);
    st({2'h0, mode_status_i, 12'h380}, 16'hb380);
    index_seen_i = 1'b1;
    {warning_i, sync_i} = 2'h0;
    tick(8);
    st(16'h8200, 16'h8380);
    $display("test status bits done");
    acc(1'b1, IDX_LIMITS, SUB_MIN, 32'h0000_0064, 32'h0, 32'h0, 1'b0);
    acc(1'b1, IDX_LIMITS, SUB_MAX, 32'h0000_01f4, 32'h0, 32'h0, 1'b0);
    rdv(IDX_LIMITS, SUB_MAX, 32'h0000_01f4);
    walk(3);
    ct = '{16'h0064 + 16'($urandom_range(400)), 16'h0300, 16'h0010};
    ce = '{ct[0], 16'h01f4, 16'h0064};
    for (int k = 0; k < 3; k++)
    begin
      acc(1'b1, IDX_TARGET, SUB_COUNT, {16'h0, ct[k]}, 32'h0, 32'h0, 1'b0);
      u_ctl.pulse();
      tick(2);
      rdv(IDX_TARGET, SUB_COUNT, {16'h0, ct[k]});
      rdv(IDX_DEMAND, SUB_COUNT, {16'h0, ce[k]});
      st({4'h0, k > 0, 11'h0}, 16'h0c00);
    end
    for (int k = 0; k < 5; k++)
    begin
      op_mode_i = hm[k];
      cmdset(16'h010f);
      rdv(IDX_DEMAND, SUB_COUNT, 32'h0);
      check({31'h0, halt_o}, 32'h1);
      check({16'h0, speed_demand_o}, 32'h0);
      check({31'h0, state_word_o[ST_GOAL]}, 32'h1);
    end
    op_mode_i = 8'h06;
    cmdset(16'h010f);
    rdv(IDX_DEMAND, SUB_COUNT, 32'h0000_0064);
    check({31'h0, halt_o}, 32'h0);
    check({16'h0, speed_demand_o}, 32'h0000_0064);
    mb = 4'($urandom);
    cmdset({6'h0, mb[3], 2'h0, mb[2:0], 4'hf});
    check({28'h0, mode_specific_bits_o}, {28'h0, mb});
    $display("test clamp and halt done");
    {open_loop_i, speed_calc_i, speed_encoder_i} = {1'b1, 32'($urandom)};
    tick(3);
    rdv(IDX_ACTUAL, SUB_COUNT, {16'h0, speed_calc_i});
    speed_src_encoder_i = 1'b1;
    tick(3);
    rdv(IDX_ACTUAL, SUB_COUNT, {16'h0, speed_encoder_i});
    $display("test actual source done");
    fault_i = 1'b1;
    tick(6);
    u_ctl.pulse();
    tick(3);
    st(16'h000f, 16'h004f);
    fault_react_done_i = 1'b1;
    tick(6);
    u_ctl.pulse();
    tick(3);
    st(16'h0008, 16'h004f);
    {fault_i, fault_react_done_i} = 2'h0;
    tick(6);
    cmdset(16'h0080);
    st(16'h0040, 16'h006f);
    $display("test fault clear done");
    tick(3);
    end_sim();
  end
endmodule
